// [dv/lps_sys_model.sv]
`timescale 1ns/1ps
// system logic stand-in: stop request and acknowledge responses
module lps_sys_model (
    // clock
    input  wire logic        clk,
    // test control
    input  wire logic        want_stop,
    input  wire logic        slow,
    // device side
    input  wire logic        special_bus_cycle,
    input  wire logic        pending_break_out_n,
    input  wire logic [12:0] power_state,
    output logic             stop_clock_request_n,
    output logic             sbc_resp
);
    logic       wq = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [3:0] pc = 4'h0;
    wire        in_grant = power_state == lps_pkg::ST_STOP_GRANT;

    initial begin
        stop_clock_request_n = 1'b1;
        sbc_resp = 1'b0;
    end

    // answer every acknowledge, however many come, prompt or slow
    always @(negedge clk) begin
        sbc_resp <= 1'b0;
        if (special_bus_cycle && !sbc_resp) begin
            if (dly >= (slow ? 4'h5 : 4'h0)) begin
                sbc_resp <= 1'b1;
                dly <= 4'h0;
            end else begin
                dly <= dly + 4'h1;
            end
        end
    end

    // hold the request until want_stop drops in stop-grant; a pending break ends it late
    always @(negedge clk) begin
        wq <= want_stop;
        pc <= pending_break_out_n ? 4'h0 : pc + 4'h1;
        if (want_stop && !wq)
            stop_clock_request_n <= 1'b0;
        else if (in_grant && (!want_stop || pc == 4'h6))
            stop_clock_request_n <= 1'b1;
    end
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
    logic        clk, srst, want_stop, slow, stop_clock_request_n;
    logic        system_mgmt_irq_n, init_n, bus_reinit_n, fsb_irq;
    logic [1:0]  local_irq_lines, halt_exec, lp_clk_en, h;
    logic        snoop_req, snoop_done, ehalt_enable, special_bus_cycle;
    logic        sbc_lp, sbc_resp, core_ratio_low, pending_break_out_n;
    logic [5:0]  voltage_id_code, event_service;
    logic        snoop_active;
    logic [12:0] power_state, last;
    logic [12:0] exp_st[$];
    logic [5:0]  exp_ev[$];
    int          cyc = 0, t_resp = 0, n_ack = 0;
    int          n_mismatch = 0, cmp_count = 0;

    lps_ctrl i_dut (.clk, .srst, .stop_clock_request_n, .system_mgmt_irq_n,
        .init_n, .bus_reinit_n, .local_irq_lines, .fsb_irq, .snoop_req,
        .snoop_done, .halt_exec, .lp_clk_en, .ehalt_enable,
        .special_bus_cycle, .sbc_lp, .sbc_resp, .core_ratio_low,
        .voltage_id_code, .pending_break_out_n, .event_service,
        .snoop_active, .power_state);
    lps_sys_model i_sys (.clk, .want_stop, .slow, .special_bus_cycle,
        .pending_break_out_n, .power_state, .stop_clock_request_n,
        .sbc_resp);

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic q(input logic [12:0] s);
        exp_st.push_back(s);
    endtask
    task automatic drv(input logic [5:0] m);
        system_mgmt_irq_n = !m[0];
        init_n = !m[1];
        bus_reinit_n = !m[2];
        local_irq_lines = m[4:3];
        fsb_irq = m[5];
    endtask
    task automatic pulse_ev(input logic [5:0] m);
        @(negedge clk) drv(m);
        @(negedge clk) drv(6'h00);
    endtask
    // bounded wait; a state never reached shows as a mismatch
    task automatic wait_st(input logic [12:0] s);
        int i;
        i = 0;
        while (power_state !== s && i < 300) begin
            @(posedge clk) #1;
            i++;
        end
        chk(power_state, s);
    endtask
    task automatic snoop(input logic [12:0] s, input logic [5:0] v);
        @(negedge clk) snoop_req = 1'b1;
        wait_st(s);
        chk(snoop_active, 1'b1);
        chk(voltage_id_code, v);
        repeat ($urandom % 4) @(posedge clk);
        @(negedge clk) snoop_done = 1'b1;
        @(negedge clk) snoop_done = 1'b0;
        snoop_req = 1'b0;
    endtask
    task automatic stop_in;
        q(lps_pkg::ST_SBC_ISSUE);
        q(lps_pkg::ST_GRANT_DLY);
        q(lps_pkg::ST_STOP_GRANT);
        @(negedge clk) slow = 1'($urandom % 2);
        want_stop = 1'b1;
        wait_st(lps_pkg::ST_STOP_GRANT);
    endtask
    task automatic stop_out(input logic [12:0] back);
        q(back);
        @(negedge clk) want_stop = 1'b0;
        wait_st(back);
    endtask

    ////////////////////////////////////////////////////////////////////
    // watcher: state moves and service pulses against the queued notes
    always @(posedge clk) begin
        if (sbc_resp && special_bus_cycle) begin
            chk(13'(sbc_lp), 13'(n_ack));
            n_ack++;
            t_resp = cyc + 1;
        end
        #1;
        cyc++;
        if (!srst && power_state !== last) begin
            if (last === lps_pkg::ST_GRANT_DLY) begin
                chk(13'(n_ack), 13'h0002);
                chk(13'(cyc - t_resp), 13'h0014);
                n_ack = 0;
            end
            chk(power_state, exp_st.size() ? exp_st.pop_front()
                                           : 13'h0);
        end
        if (!srst && event_service !== 6'h00)
            chk(event_service, exp_ev.size() ? exp_ev.pop_front()
                                             : 6'h0);
        last = power_state;
    end

    // hang guard, far beyond the expected run
    initial begin
        #400000;
        n_mismatch++;
        final_report;
    end

    initial begin
        clk = 1'b0;
        srst = 1'b1;
        {want_stop, slow, snoop_req, snoop_done, ehalt_enable} = 5'h00;
        halt_exec = 2'b00;
        drv(6'h00);
        void'($urandom(84));
        repeat (8) @(posedge clk);
        @(negedge clk) srst = 1'b0;
        chk(power_state, lps_pkg::ST_NORMAL);
        chk(voltage_id_code, 6'h20);
        chk(lp_clk_en, 2'b11);
        $display("test reset done");
        // reset inside stop-grant keeps the state
        stop_in();
        @(negedge clk) srst = 1'b1;
        @(negedge clk) srst = 1'b0;
        chk(power_state, lps_pkg::ST_STOP_GRANT);
        chk(pending_break_out_n, 1'b1);
        stop_out(lps_pkg::ST_NORMAL);
        $display("test stop done");
        // snoop, then events latched twice, pending break ends grant
        stop_in();
        q(lps_pkg::ST_GRANT_SNOOP);
        q(lps_pkg::ST_STOP_GRANT);
        snoop(lps_pkg::ST_GRANT_SNOOP, 6'h20);
        wait_st(lps_pkg::ST_STOP_GRANT);
        q(lps_pkg::ST_GRANT_SNOOP);
        q(lps_pkg::ST_STOP_GRANT);
        q(lps_pkg::ST_NORMAL);
        exp_ev.push_back(6'h2F);
        pulse_ev(6'h20);
        pulse_ev(6'h0F);
        pulse_ev(6'h0F);
        chk(event_service, 6'h00);
        chk(pending_break_out_n, 1'b0);
        wait_st(lps_pkg::ST_NORMAL);
        @(negedge clk) want_stop = 1'b0;
        $display("test grant done");
        // halt on both cpus, each break event in turn
        for (int k = 0; k < 6; k++) begin
            h = 2'(1 << ($urandom % 2));
            @(negedge clk) halt_exec = h;
            @(posedge clk) #1;
            chk(lp_clk_en, 2'(~h));
            q(lps_pkg::ST_HALT);
            @(negedge clk) halt_exec = 2'b11;
            wait_st(lps_pkg::ST_HALT);
            chk(lp_clk_en, 2'b00);
            if (k == 0) begin
                q(lps_pkg::ST_HALT_SNOOP);
                q(lps_pkg::ST_HALT);
                snoop(lps_pkg::ST_HALT_SNOOP, 6'h20);
                wait_st(lps_pkg::ST_HALT);
                stop_in();
                stop_out(lps_pkg::ST_HALT);
            end
            q(lps_pkg::ST_NORMAL);
            exp_ev.push_back(6'(1 << k));
            pulse_ev(6'(1 << k));
            wait_st(lps_pkg::ST_NORMAL);
            @(negedge clk) halt_exec = 2'b00;
        end
        $display("test halt done");
        // enhanced halt: ramp down, snoop at low point, ramp up
        q(lps_pkg::ST_EH_RATIO);
        q(lps_pkg::ST_EH_VID);
        q(lps_pkg::ST_EHALT);
        @(negedge clk) ehalt_enable = 1'b1;
        halt_exec = 2'b11;
        wait_st(lps_pkg::ST_EH_RATIO);
        chk({core_ratio_low, voltage_id_code}, 7'h60);
        wait_st(lps_pkg::ST_EHALT);
        chk(voltage_id_code, 6'h26);
        q(lps_pkg::ST_EH_SNOOP);
        q(lps_pkg::ST_EHALT);
        snoop(lps_pkg::ST_EH_SNOOP, 6'h26);
        wait_st(lps_pkg::ST_EHALT);
        chk(core_ratio_low, 1'b1);
        q(lps_pkg::ST_EX_VID);
        q(lps_pkg::ST_EX_RATIO);
        q(lps_pkg::ST_NORMAL);
        exp_ev.push_back(6'h10);
        pulse_ev(6'h10);
        wait_st(lps_pkg::ST_EX_VID);
        chk(core_ratio_low, 1'b1);
        wait_st(lps_pkg::ST_EX_RATIO);
        chk(voltage_id_code, 6'h20);
        wait_st(lps_pkg::ST_NORMAL);
        chk(core_ratio_low, 1'b0);
        $display("test ehalt done");
        final_report;
    end
endmodule

// [src/lps_ctrl.sv]
`timescale 1ns/1ps
module lps_ctrl (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // stop-clock request from system logic
    input  wire logic       stop_clock_request_n,
    // wakeup events
    input  wire logic       system_mgmt_irq_n,
    input  wire logic       init_n,
    input  wire logic       bus_reinit_n,
    input  wire logic [1:0] local_irq_lines,
    input  wire logic       fsb_irq,
    // bus snoop
    input  wire logic       snoop_req,
    input  wire logic       snoop_done,
    // logical processors
    input  wire logic [1:0] halt_exec,
    output logic      [1:0] lp_clk_en,
    // configuration
    input  wire logic       ehalt_enable,
    // stop-grant acknowledge cycle
    output logic            special_bus_cycle,
    output logic            sbc_lp,
    input  wire logic       sbc_resp,
    // operating point
    output logic            core_ratio_low,
    output logic      [5:0] voltage_id_code,
    // status
    output logic            pending_break_out_n,
    output logic      [5:0] event_service,
    output logic            snoop_active,
    output logic     [12:0] power_state
);

    lps_pkg::lps_state_e state;
    lps_pkg::lps_state_e next_state;
    logic [7:0]          cnt;
    logic                ret_halt;
    logic                ret_eh;
    logic                all_halt_q;

    lps_evt_if ev ();

    ////////////////////////////////////////////////////////////////////////
    // one step of the voltage code toward a target
    function automatic logic [5:0] vid_step(input logic [5:0] cur,
                                            input logic [5:0] tgt);
        if (cur < tgt) begin
            vid_step = cur + 6'h01;
        end else if (cur > tgt) begin
            vid_step = cur - 6'h01;
        end else begin
            vid_step = cur;
        end
    endfunction

    // counter preload when a state is entered
    function automatic logic [7:0] cnt_load(input lps_pkg::lps_state_e s);
        case (s)
            lps_pkg::ST_GRANT_DLY: cnt_load = lps_pkg::GRANT_DLY_CLK
                                            - 8'h01;
            lps_pkg::ST_EH_RATIO,
            lps_pkg::ST_EX_RATIO:  cnt_load = lps_pkg::RATIO_SETTLE_CLK
                                            - 8'h01;
            lps_pkg::ST_EH_VID,
            lps_pkg::ST_EX_VID:    cnt_load = lps_pkg::VID_STEP_CLK
                                            - 8'h01;
            default:               cnt_load = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire stop_req  = ~stop_clock_request_n;
    wire all_halt  = &halt_exec;
    wire halt_rise = all_halt & ~all_halt_q;
    wire brk       = |ev.svc;
    wire last_ack  = (sbc_lp == 1'(lps_pkg::LP_NUM - 1));
    wire cnt_zero  = (cnt == 8'h00);
    wire vid_tick  = cnt_zero & (state == lps_pkg::ST_EH_VID
                               | state == lps_pkg::ST_EX_VID);
    wire in_grant  = (state == lps_pkg::ST_STOP_GRANT)
                   | (state == lps_pkg::ST_GRANT_SNOOP);
    wire nx_grant  = (next_state == lps_pkg::ST_STOP_GRANT)
                   | (next_state == lps_pkg::ST_GRANT_SNOOP);
    wire enter     = (next_state != state);
    wire grant_snoop_end = snoop_done
                         | (~snoop_req & ev.pend[lps_pkg::EV_FSB]);

    // event channel: latch while granted, hand over on exit
    assign ev.raw     = {fsb_irq, local_irq_lines, ~bus_reinit_n,
                         ~init_n, ~system_mgmt_irq_n};
    assign ev.hold    = in_grant;
    assign ev.handover = in_grant & ~nx_grant;

    assign special_bus_cycle = (state == lps_pkg::ST_SBC_ISSUE);
    assign snoop_active = (state == lps_pkg::ST_GRANT_SNOOP)
                        | (state == lps_pkg::ST_HALT_SNOOP)
                        | (state == lps_pkg::ST_EH_SNOOP);
    assign event_service = ev.svc;
    assign power_state   = state;

    lps_event_latch u_latch (
        .clk  (clk),
        .srst (srst),
        .ev   (ev)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state; stop request wins over halt entry and break events; the halt snoop states ignore it
    always_comb begin
        next_state = state;
        case (state)
            lps_pkg::ST_NORMAL: begin
                if (stop_req) begin
                    next_state = lps_pkg::ST_SBC_ISSUE;
                end else if (halt_rise) begin
                    next_state = ehalt_enable ? lps_pkg::ST_EH_RATIO
                                              : lps_pkg::ST_HALT;
                end
            end
            lps_pkg::ST_SBC_ISSUE: begin
                if (sbc_resp && last_ack) begin
                    next_state = lps_pkg::ST_GRANT_DLY;
                end
            end
            lps_pkg::ST_GRANT_DLY: begin
                if (cnt_zero) begin
                    next_state = lps_pkg::ST_STOP_GRANT;
                end
            end
            lps_pkg::ST_STOP_GRANT: begin
                if (!stop_req) begin
                    next_state = ret_eh   ? lps_pkg::ST_EHALT
                               : ret_halt ? lps_pkg::ST_HALT
                               : lps_pkg::ST_NORMAL;
                end else if (snoop_req || fsb_irq) begin
                    next_state = lps_pkg::ST_GRANT_SNOOP;
                end
            end
            lps_pkg::ST_GRANT_SNOOP: begin
                if (grant_snoop_end) begin
                    next_state = lps_pkg::ST_STOP_GRANT;
                end
            end
            lps_pkg::ST_HALT: begin
                if (stop_req) begin
                    next_state = lps_pkg::ST_SBC_ISSUE;
                end else if (brk) begin
                    next_state = lps_pkg::ST_NORMAL;
                end else if (snoop_req) begin
                    next_state = lps_pkg::ST_HALT_SNOOP;
                end
            end
            lps_pkg::ST_HALT_SNOOP: begin
                if (brk) begin
                    next_state = lps_pkg::ST_NORMAL;
                end else if (snoop_done) begin
                    next_state = lps_pkg::ST_HALT;
                end
            end
            lps_pkg::ST_EH_RATIO: begin
                if (cnt_zero) begin
                    next_state = lps_pkg::ST_EH_VID;
                end
            end
            lps_pkg::ST_EH_VID: begin
                if (voltage_id_code == lps_pkg::VID_LOW) begin
                    next_state = lps_pkg::ST_EHALT;
                end
            end
            lps_pkg::ST_EHALT: begin
                if (stop_req) begin
                    next_state = lps_pkg::ST_SBC_ISSUE;
                end else if (brk) begin
                    next_state = lps_pkg::ST_EX_VID;
                end else if (snoop_req) begin
                    next_state = lps_pkg::ST_EH_SNOOP;
                end
            end
            lps_pkg::ST_EH_SNOOP: begin
                if (brk) begin
                    next_state = lps_pkg::ST_EX_VID;
                end else if (snoop_done) begin
                    next_state = lps_pkg::ST_EHALT;
                end
            end
            lps_pkg::ST_EX_VID: begin
                if (voltage_id_code == lps_pkg::VID_NOM) begin
                    next_state = lps_pkg::ST_EX_RATIO;
                end
            end
            lps_pkg::ST_EX_RATIO: begin
                if (cnt_zero) begin
                    next_state = lps_pkg::ST_NORMAL;
                end
            end
            default: next_state = lps_pkg::ST_NORMAL;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state; a reset taken in stop-grant leaves the device there
    always_ff @(posedge clk) begin
        // an unknown state at power-up falls through to normal
        if (srst && state == lps_pkg::ST_STOP_GRANT) begin
            state <= lps_pkg::ST_STOP_GRANT;
        end else if (srst) begin
            state <= lps_pkg::ST_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // shared delay counter, reloaded per voltage step
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt <= 8'h00;
        end else if (enter) begin
            cnt <= cnt_load(next_state);
        end else if (vid_tick) begin
            cnt <= lps_pkg::VID_STEP_CLK - 8'h01;
        end else if (!cnt_zero) begin
            cnt <= cnt - 8'h01;
        end
    end

    // acknowledge counter: one cycle per logical processor
    always_ff @(posedge clk) begin
        if (srst || state != lps_pkg::ST_SBC_ISSUE) begin
            sbc_lp <= 1'b0;
        end else if (sbc_resp && !last_ack) begin
            sbc_lp <= 1'b1;
        end
    end

    // where stop-grant returns to
    always_ff @(posedge clk) begin
        if (srst) begin
            ret_halt <= 1'b0;
            ret_eh   <= 1'b0;
        end else if (next_state == lps_pkg::ST_SBC_ISSUE && enter) begin
            ret_halt <= (state == lps_pkg::ST_HALT);
            ret_eh   <= (state == lps_pkg::ST_EHALT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core ratio only; the bus clock is never touched here
    always_ff @(posedge clk) begin
        if (srst) begin
            core_ratio_low <= 1'b0;
        end else if (enter && next_state == lps_pkg::ST_EH_RATIO) begin
            core_ratio_low <= 1'b1;
        end else if (enter && next_state == lps_pkg::ST_EX_RATIO) begin
            core_ratio_low <= 1'b0;
        end
    end

    // voltage code walks one table entry per step
    always_ff @(posedge clk) begin
        if (srst) begin
            voltage_id_code <= lps_pkg::VID_NOM;
        end else if (vid_tick && state == lps_pkg::ST_EH_VID) begin
            voltage_id_code <= vid_step(voltage_id_code,
                                        lps_pkg::VID_LOW);
        end else if (vid_tick) begin
            voltage_id_code <= vid_step(voltage_id_code,
                                        lps_pkg::VID_NOM);
        end
    end

    // pending-break flags any latched event while in stop-grant or grant snoop
    always_ff @(posedge clk) begin
        if (srst) begin
            pending_break_out_n <= 1'b1;
            lp_clk_en           <= 2'b11;
            all_halt_q          <= 1'b0;
        end else begin
            pending_break_out_n <= ~(in_grant & |ev.pend);
            lp_clk_en  <= (next_state == lps_pkg::ST_NORMAL)
                        ? ~halt_exec : 2'b00;
            all_halt_q <= all_halt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_grant_delay: assert property (@(posedge clk) disable iff (srst)
        state == lps_pkg::ST_SBC_ISSUE && sbc_resp && last_ack
        |-> ##20 state == lps_pkg::ST_GRANT_DLY
            ##1 state == lps_pkg::ST_STOP_GRANT)
        else $error("stop-grant not entered 20 clocks after response");

    a_sbc_per_lp: assert property (@(posedge clk) disable iff (srst)
        special_bus_cycle && sbc_resp && !sbc_lp
        |=> special_bus_cycle && sbc_lp)
        else $error("second acknowledge cycle missing");

    a_halt_entry: assert property (@(posedge clk) disable iff (srst)
        state == lps_pkg::ST_NORMAL && halt_rise && !stop_req
        && !ehalt_enable |=> state == lps_pkg::ST_HALT)
        else $error("halt not entered with all cpus halted");

    a_halt_break: assert property (@(posedge clk) disable iff (srst)
        state == lps_pkg::ST_HALT && brk && !stop_req
        |=> state == lps_pkg::ST_NORMAL ##1 lp_clk_en == ~$past(halt_exec))
        else $error("halt did not end on break event");

    a_halt_return: assert property (@(posedge clk) disable iff (srst)
        state == lps_pkg::ST_STOP_GRANT && ret_halt && !ret_eh
        && !stop_req |=> state == lps_pkg::ST_HALT)
        else $error("stop-grant did not return to halt");

    a_ratio_first: assert property (@(posedge clk) disable iff (srst)
        $rose(core_ratio_low) |-> voltage_id_code == lps_pkg::VID_NOM)
        else $error("voltage code moved before ratio");

    a_vid_first: assert property (@(posedge clk) disable iff (srst)
        $fell(core_ratio_low) |-> $past(voltage_id_code)
                                  == lps_pkg::VID_NOM)
        else $error("ratio restored before voltage code");

    a_vid_at_low: assert property (@(posedge clk) disable iff (srst)
        state == lps_pkg::ST_EH_SNOOP
        |-> core_ratio_low && voltage_id_code == lps_pkg::VID_LOW)
        else $error("operating point left low in snoop");

    a_grant_exit: assert property (@(posedge clk) disable iff (srst)
        state == lps_pkg::ST_STOP_GRANT && !stop_req && !ret_halt
        && !ret_eh |=> state == lps_pkg::ST_NORMAL)
        else $error("stop-grant did not return to normal");

    a_grant_snoop: assert property (@(posedge clk) disable iff (srst)
        state == lps_pkg::ST_STOP_GRANT && stop_req && snoop_req
        |=> state == lps_pkg::ST_GRANT_SNOOP)
        else $error("snoop in stop-grant not taken");

    a_bus_reinit_n_held: assert property (@(posedge clk) disable iff (srst)
        state == lps_pkg::ST_STOP_GRANT && stop_req
        && $fell(bus_reinit_n)
        |=> !event_service[lps_pkg::EV_BUS_REINIT_N]
            && ev.pend[lps_pkg::EV_BUS_REINIT_N])
        else $error("bus reinit serviced in stop-grant");

    a_break_flag: assert property (@(posedge clk) disable iff (srst)
        state == lps_pkg::ST_STOP_GRANT && |ev.pend
        |=> !pending_break_out_n)
        else $error("pending-break not asserted");

    a_one_state: assert property (@(posedge clk) disable iff (srst)
        $onehot(state))
        else $error("power state not one-hot");

endmodule

// [src/lps_event_latch.sv]
`timescale 1ns/1ps
module lps_event_latch (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // event channel to the controller
    lps_evt_if.latch ev
);

    logic [5:0] raw_q;
    logic [5:0] lat;
    logic [5:0] svc;

    ////////////////////////////////////////////////////////////////////////
    // edge detect: a held level counts once, so one occurrence per event
    wire [5:0] edge_hit  = ev.raw & ~raw_q;
    // an edge in the handover cycle leaves with the rest, never lost
    wire [5:0] next_lat  = ev.handover ? 6'h00
                         : (lat | (ev.hold ? edge_hit : 6'h00));
    wire [5:0] next_svc  = ev.handover ? (lat | edge_hit)
                         : (ev.hold ? 6'h00 : edge_hit);

    assign ev.pend = lat;
    assign ev.svc  = svc;

    // event registers
    always_ff @(posedge clk) begin
        if (srst) begin
            raw_q <= 6'h00;
            lat   <= 6'h00;
            svc   <= 6'h00;
        end else begin
            raw_q <= ev.raw;
            lat   <= next_lat;
            svc   <= next_svc;
        end
    end

endmodule

// [src/lps_evt_if.sv]
`timescale 1ns/1ps
interface lps_evt_if;
    logic       hold;     // latch instead of service
    logic       handover; // hand over everything latched
    logic [5:0] raw;      // live event levels, active high
    logic [5:0] pend;     // latched, not yet serviced
    logic [5:0] svc;      // one-cycle service pulses

    modport latch (input hold, input handover, input raw,
                   output pend, output svc);
    modport ctrl  (output hold, output handover, output raw,
                   input pend, input svc);
endinterface

// [src/lps_pkg.sv]
package lps_pkg;

    ////////////////////////////////////////////////////////////////////////
    // power states, one-hot
    typedef enum logic [12:0] {
        ST_NORMAL      = 13'h0001,
        ST_SBC_ISSUE   = 13'h0002,
        ST_GRANT_DLY   = 13'h0004,
        ST_STOP_GRANT  = 13'h0008,
        ST_GRANT_SNOOP = 13'h0010,
        ST_HALT        = 13'h0020,
        ST_HALT_SNOOP  = 13'h0040,
        ST_EH_RATIO    = 13'h0080,
        ST_EH_VID      = 13'h0100,
        ST_EHALT       = 13'h0200,
        ST_EH_SNOOP    = 13'h0400,
        ST_EX_VID      = 13'h0800,
        ST_EX_RATIO    = 13'h1000
    } lps_state_e;

    ////////////////////////////////////////////////////////////////////////
    // logical processors sharing the stop-clock request
    localparam int unsigned LP_NUM = 2;

    // wakeup event positions in the event vectors
    localparam int unsigned EV_SMI   = 0;
    localparam int unsigned EV_INIT  = 1;
    localparam int unsigned EV_BUS_REINIT_N = 2;
    localparam int unsigned EV_LINT0 = 3;
    localparam int unsigned EV_LINT1 = 4;
    localparam int unsigned EV_FSB   = 5;
    localparam int unsigned EV_NUM   = 6;

    ////////////////////////////////////////////////////////////////////////
    // timing, in bus clocks (clk is the bus clock)
    localparam logic [7:0] GRANT_DLY_CLK    = 8'h14;  // 20 bus clocks
    localparam logic [7:0] RATIO_SETTLE_CLK = 8'h08;
    localparam logic [7:0] VID_STEP_CLK     = 8'h04;

    // operating points
    localparam logic [5:0] VID_NOM = 6'h20;
    localparam logic [5:0] VID_LOW = 6'h26;

endpackage
